// ---- pts_params.svh ----
// Constants for the period timer: register offsets, field positions,
// reset values and scaler limits.
// Assumes the includer needs plain `define macros only.
`ifndef PTS_PARAMS_SVH
`define PTS_PARAMS_SVH

// Register offsets on the plain register port
`define PTS_ADDR_GLOBAL_CTRL  8'h0b
`define PTS_ADDR_PERIPH_FLAGS 8'h0c
`define PTS_ADDR_TIMER_COUNT  8'h11
`define PTS_ADDR_TIMER_CTRL   8'h12
`define PTS_ADDR_PERIPH_ENS   8'h8c
`define PTS_ADDR_TIMER_PERIOD 8'h92

// Reset values
`define PTS_COUNT_RST   8'h00
`define PTS_PERIOD_RST  8'hff
`define PTS_CTRL_RST    7'h00
`define PTS_BYTE_ZERO   8'h00

// Field positions
`define PTS_GLOBAL_EN_BIT 7
`define PTS_PERIPH_EN_BIT 6
`define PTS_MATCH_FLAG_BIT 1
`define PTS_MATCH_EN_BIT  1
`define PTS_POST_MSB      6
`define PTS_POST_LSB      3
`define PTS_ON_BIT        2
`define PTS_PRE_MSB       1
`define PTS_PRE_LSB       0

// Scaler terminal counts (ratio minus one)
`define PTS_INSTR_LAST  4'h3
`define PTS_PRE1_LAST   4'h0
`define PTS_PRE4_LAST   4'h3
`define PTS_PRE16_LAST  4'hf

`endif

// ---- pts_pkg.sv ----
// Types shared by the period timer and its users.
// Assumes an 8-bit register port and an 8-bit timer.
package pts_pkg;

    // One register access from software
    typedef struct packed {
        logic [7:0] addr;    // Register offset
        logic [7:0] wrData;  // Write data
        logic       wr;      // Write strobe
        logic       rd;      // Read strobe
    } pts_bus_req_t;

    // Time base handed to the PWM unit
    typedef struct packed {
        logic [7:0] count;   // Current timer count
        logic       reload;  // Count wrapped on period match
    } pts_pwm_base_t;

    // Prescale select codes
    typedef enum logic [1:0] {
        PTS_PRE_DIV1  = 2'b00,
        PTS_PRE_DIV4  = 2'b01,
        PTS_PRE_DIV16 = 2'b10,
        PTS_PRE_DIV16B = 2'b11
    } pts_prescale_t;

endpackage : pts_pkg

// ---- pts_scaler.sv ----
// Four-bit wrapping divider used for the instruction clock, the
// prescaler and the postscaler.
// Assumes en, clr and last come from logic on the same clock.
`timescale 1ns/100ps
module pts_scaler (
    input  wire logic       clk,   // System clock
    input  wire logic       rst,   // Synchronous reset, active high
    input  wire logic       clr,   // Clear the count
    input  wire logic       en,    // Count enable
    input  wire logic [3:0] last,  // Terminal count
    output logic            tick   // Terminal count reached while enabled
);

    logic [3:0] cnt_q;

    assign tick = en && (cnt_q >= last);

    always_ff @(posedge clk) begin
        if (rst || clr) begin
            cnt_q <= 4'h0;
        end else if (tick) begin
            cnt_q <= 4'h0;
        end else if (en) begin
            cnt_q <= cnt_q + 4'h1;
        end
    end

endmodule : pts_scaler

// ---- pts_timer.sv ----
// Eight-bit period timer with prescaler, postscaler, match flag and
// interrupt request, reached over a plain register port.
// Assumes clk is the oscillator clock and rst a synchronous reset.
//
// What this block does
// - Eight-bit count register, software read/write, cleared by every reset.
// - Input is oscillator over four, prescaled 1, 4 or 16 by control bits 1:0.
// - Count rises from zero to the period value, then wraps to zero.
// - Eight-bit period register, software read/write, reset to all ones.
// - Period matches feed a postscaler of ratio bits 6:3 plus one; completion sets flag.
// - Control bit 2 turns the timer on; cleared stops counting.
// - Count write, control write or reset clear both scaler counters.
// - A control write leaves the count unchanged.
// - Raw period match pulse is offered as serial unit shift clock source.
// - Timer provides the period time base for the PWM unit.
//
// The strobed register port was chosen for this implementation.
`include "pts_params.svh"
`timescale 1ns/100ps
module pts_timer
    import pts_pkg::*;
(
    input  wire logic          clk,           // Oscillator clock, 40 MHz
    input  wire logic          rst,           // Synchronous reset, active high
    input  wire pts_bus_req_t  busReq,        // Register access request
    output logic [7:0]         rdData_q,      // Read data, cycle after strobe
    output pts_pwm_base_t      pwmBase_q,     // Time base for PWM unit
    output logic               sspShiftTick_q, // Match pulse for serial unit
    output logic               irqReq_q       // Interrupt request, level
);

    // Register state
    logic [7:0] timerCount_q;
    logic [7:0] timerPeriod_q;
    logic [6:0] timerControl_q;
    logic       periodMatchFlag_q;
    logic       periodMatchEnable_q;
    logic       globalIrqEnable_q;
    logic       peripheralIrqEnable_q;

    // Decoded writes
    logic wrCount;
    logic wrPeriod;
    logic wrControl;
    logic wrFlags;
    logic wrEnables;
    logic wrGlobal;

    // Timer datapath
    logic          timerOn;
    pts_prescale_t prescaleSelect;
    logic [3:0]    postscaleSelect;
    logic [3:0]    prescaleLast;
    logic          scalerClear;
    logic          instrTick;
    logic          preTick;
    logic          periodMatch;
    logic          postDone;
    logic [7:0]    rdValue;

    always_comb begin
        wrCount   = 1'b0;
        wrPeriod  = 1'b0;
        wrControl = 1'b0;
        wrFlags   = 1'b0;
        wrEnables = 1'b0;
        wrGlobal  = 1'b0;
        if (busReq.wr) begin
            if (busReq.addr == `PTS_ADDR_TIMER_COUNT) begin
                wrCount = 1'b1;
            end else if (busReq.addr == `PTS_ADDR_TIMER_PERIOD) begin
                wrPeriod = 1'b1;
            end else if (busReq.addr == `PTS_ADDR_TIMER_CTRL) begin
                wrControl = 1'b1;
            end else if (busReq.addr == `PTS_ADDR_PERIPH_FLAGS) begin
                wrFlags = 1'b1;
            end else if (busReq.addr == `PTS_ADDR_PERIPH_ENS) begin
                wrEnables = 1'b1;
            end else if (busReq.addr == `PTS_ADDR_GLOBAL_CTRL) begin
                wrGlobal = 1'b1;
            end
        end
    end

    // Control fields
    assign timerOn         = timerControl_q[`PTS_ON_BIT];
    assign prescaleSelect  = pts_prescale_t'(timerControl_q[`PTS_PRE_MSB:`PTS_PRE_LSB]);
    assign postscaleSelect = timerControl_q[`PTS_POST_MSB:`PTS_POST_LSB];

    always_comb begin
        case (prescaleSelect)
            PTS_PRE_DIV1: prescaleLast = `PTS_PRE1_LAST;
            PTS_PRE_DIV4: prescaleLast = `PTS_PRE4_LAST;
            default:      prescaleLast = `PTS_PRE16_LAST;
        endcase
    end

    // Either write clears both scalers; reset reaches them directly
    assign scalerClear = wrCount || wrControl;

    // Instruction clock: one enable pulse every four oscillator cycles
    pts_scaler u_instr (
        .clk  (clk),
        .rst  (rst),
        .clr  (1'b0),
        .en   (1'b1),
        .last (`PTS_INSTR_LAST),
        .tick (instrTick)
    );

    // Prescaler halts with the timer; only the instruction divider keeps counting while off
    pts_scaler u_pre (
        .clk  (clk),
        .rst  (rst),
        .clr  (scalerClear),
        .en   (instrTick && timerOn),
        .last (prescaleLast),
        .tick (preTick)
    );

    // A count write in the same cycle wins, so no match is taken then
    assign periodMatch = preTick && !wrCount && (timerCount_q == timerPeriod_q);

    pts_scaler u_post (
        .clk  (clk),
        .rst  (rst),
        .clr  (scalerClear),
        .en   (periodMatch),
        .last (postscaleSelect),
        .tick (postDone)
    );

    // Timer count
    always_ff @(posedge clk) begin
        if (rst) begin
            timerCount_q <= `PTS_COUNT_RST;
        end else if (wrCount) begin
            timerCount_q <= busReq.wrData;
        end else if (periodMatch) begin
            timerCount_q <= `PTS_COUNT_RST;
        end else if (preTick) begin
            timerCount_q <= timerCount_q + 8'h01;
        end
    end

    // Period register
    always_ff @(posedge clk) begin
        if (rst) begin
            timerPeriod_q <= `PTS_PERIOD_RST;
        end else if (wrPeriod) begin
            timerPeriod_q <= busReq.wrData;
        end
    end

    // Control register; the count is not touched here
    always_ff @(posedge clk) begin
        if (rst) begin
            timerControl_q <= `PTS_CTRL_RST;
        end else if (wrControl) begin
            timerControl_q <= busReq.wrData[6:0];
        end
    end

    // Match flag: a postscaler completion beats a same-cycle clear
    always_ff @(posedge clk) begin
        if (rst) begin
            periodMatchFlag_q <= 1'b0;
        end else if (postDone) begin
            periodMatchFlag_q <= 1'b1;
        end else if (wrFlags) begin
            periodMatchFlag_q <= busReq.wrData[`PTS_MATCH_FLAG_BIT];
        end
    end

    // Enable bits
    always_ff @(posedge clk) begin
        if (rst) begin
            periodMatchEnable_q <= 1'b0;
        end else if (wrEnables) begin
            periodMatchEnable_q <= busReq.wrData[`PTS_MATCH_EN_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            globalIrqEnable_q     <= 1'b0;
            peripheralIrqEnable_q <= 1'b0;
        end else if (wrGlobal) begin
            globalIrqEnable_q     <= busReq.wrData[`PTS_GLOBAL_EN_BIT];
            peripheralIrqEnable_q <= busReq.wrData[`PTS_PERIPH_EN_BIT];
        end
    end

    // Interrupt request
    always_ff @(posedge clk) begin
        if (rst) begin
            irqReq_q <= 1'b0;
        end else begin
            irqReq_q <= periodMatchFlag_q && periodMatchEnable_q
                        && peripheralIrqEnable_q && globalIrqEnable_q;
        end
    end

    // Outputs toward the serial unit and the PWM unit
    always_ff @(posedge clk) begin
        if (rst) begin
            sspShiftTick_q <= 1'b0;
        end else begin
            sspShiftTick_q <= periodMatch;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pwmBase_q <= '0;
        end else begin
            pwmBase_q.count  <= timerCount_q;
            pwmBase_q.reload <= periodMatch;
        end
    end

    // Readback; bits owned by other peripherals read as zero
    always_comb begin
        rdValue = `PTS_BYTE_ZERO;
        if (busReq.addr == `PTS_ADDR_TIMER_COUNT) begin
            rdValue = timerCount_q;
        end else if (busReq.addr == `PTS_ADDR_TIMER_PERIOD) begin
            rdValue = timerPeriod_q;
        end else if (busReq.addr == `PTS_ADDR_TIMER_CTRL) begin
            rdValue = {1'b0, timerControl_q};
        end else if (busReq.addr == `PTS_ADDR_PERIPH_FLAGS) begin
            rdValue[`PTS_MATCH_FLAG_BIT] = periodMatchFlag_q;
        end else if (busReq.addr == `PTS_ADDR_PERIPH_ENS) begin
            rdValue[`PTS_MATCH_EN_BIT] = periodMatchEnable_q;
        end else if (busReq.addr == `PTS_ADDR_GLOBAL_CTRL) begin
            rdValue[`PTS_GLOBAL_EN_BIT] = globalIrqEnable_q;
            rdValue[`PTS_PERIPH_EN_BIT] = peripheralIrqEnable_q;
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clk) begin
        if (rst) begin
            rdData_q <= `PTS_BYTE_ZERO;
        end else if (busReq.rd) begin
            rdData_q <= rdValue;
        end else begin
            rdData_q <= `PTS_BYTE_ZERO;
        end
    end

endmodule : pts_timer

// ---- pts_timer_sva.sv ----
// Port checker for the period timer.
// Assumes one clock and a synchronous reset; bound onto pts_timer below.
`include "pts_params.svh"
`timescale 1ns/100ps
module pts_timer_sva
    import pts_pkg::*;
(
    input  wire logic          clk,            // Clock
    input  wire logic          rst,            // Reset, active high
    input  wire pts_bus_req_t  busReq,         // Register access
    input  wire logic [7:0]    rdData_q,       // Read data
    input  wire pts_pwm_base_t pwmBase_q,      // PWM time base
    input  wire logic          sspShiftTick_q, // Raw match pulse
    input  wire logic          irqReq_q        // Interrupt request
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic wrCount;
    logic onQ;
    assign wrCount = busReq.wr && busReq.addr == `PTS_ADDR_TIMER_COUNT;
    // Shadow of the on bit, so frozen counting can be judged from the ports
    always_ff @(posedge clk) begin
        if (rst) begin
            onQ <= 1'b0;
        end else if (busReq.wr && busReq.addr == `PTS_ADDR_TIMER_CTRL) begin
            onQ <= busReq.wrData[`PTS_ON_BIT];
        end
    end
    property p_rstOut;
        $fell(rst) |-> rdData_q == 8'h00 && !pwmBase_q.reload && !irqReq_q;
    endproperty
    a_rstOut: assert property (p_rstOut) else $error("outputs not clear after reset");
    property p_rdZero;
        !busReq.rd || busReq.addr == 8'h20 |=> rdData_q == 8'h00;
    endproperty
    a_rdZero: assert property (p_rdZero) else $error("idle read data not zero");
    property p_ctrlTop;
        busReq.rd && busReq.addr == `PTS_ADDR_TIMER_CTRL |=> !rdData_q[7];
    endproperty
    a_ctrlTop: assert property (p_ctrlTop) else $error("control bit 7 reads one");
    property p_sspRaw;
        sspShiftTick_q == pwmBase_q.reload;
    endproperty
    a_sspRaw: assert property (p_sspRaw) else $error("serial tick differs from match");
    property p_wrapZero;
        pwmBase_q.reload |=> pwmBase_q.count == 8'h00;
    endproperty
    a_wrapZero: assert property (p_wrapZero) else $error("match without wrap to zero");
    property p_incGap;
        pwmBase_q.reload |=> !pwmBase_q.reload [*3];
    endproperty
    a_incGap: assert property (p_incGap) else $error("matches closer than four clocks");
    property p_countStep;
        !wrCount |-> ##2 (pwmBase_q.count == $past(pwmBase_q.count) ||
            pwmBase_q.count == $past(pwmBase_q.count) + 8'h01 || pwmBase_q.count == 8'h00);
    endproperty
    a_countStep: assert property (p_countStep) else $error("count jumped");
    property p_offFreeze;
        !onQ && !wrCount |-> ##2 $stable(pwmBase_q.count);
    endproperty
    a_offFreeze: assert property (p_offFreeze) else $error("count moved while off");
    property p_irqDrop;
        busReq.wr && (busReq.addr == 8'h0b && !(&busReq.wrData[7:6]) ||
            busReq.addr == 8'h8c && !busReq.wrData[1]) |=> ##1 !irqReq_q;
    endproperty
    a_irqDrop: assert property (p_irqDrop) else $error("request despite enable off");
endmodule : pts_timer_sva

bind pts_timer pts_timer_sva u_sva (.clk(clk), .rst(rst), .busReq(busReq),
    .rdData_q(rdData_q), .pwmBase_q(pwmBase_q), .sspShiftTick_q(sspShiftTick_q),
    .irqReq_q(irqReq_q));

// ---- pts_timer_bench.sv ----
// Self-checking bench for the period timer.
// Assumes the checker binds itself; bench drives the register port only.
`timescale 1ns/100ps
module pts_timer_bench
    import pts_pkg::*;
;
    logic          clk;
    logic          rst;
    pts_bus_req_t  busReq;
    logic [7:0]    rdData;
    pts_pwm_base_t pwmBase;
    logic          irqReq;
    int            errCount;
    int            compares;
    logic [7:0]    v;
    logic [7:0]    rstAddr [7] = '{8'h11, 8'h92, 8'h12, 8'h0c, 8'h8c, 8'h0b, 8'h20};
    logic [7:0]    rstVal  [7] = '{8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [3:0]    postSel [3] = '{4'h0, 4'h3, 4'hf};

    pts_timer uut (.clk(clk), .rst(rst), .busReq(busReq), .rdData_q(rdData),
        .pwmBase_q(pwmBase), .sspShiftTick_q(), .irqReq_q(irqReq));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            errCount++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wrReg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        busReq <= '{addr: a, wrData: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        busReq.wr <= 1'b0;
    endtask : wrReg

    task automatic rdReg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        busReq <= '{addr: a, wrData: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        busReq.rd <= 1'b0;
        #1 d = rdData;
    endtask : rdReg

    task automatic conclude();
        $display("comparisons %0d, mismatches %0d", compares, errCount);
        if (errCount == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : conclude

    initial begin
        repeat (20000) @(posedge clk);
        errCount++;
        conclude();
    end

    initial begin
        busReq = '0;
        rst = 1'b1;
        errCount = 0;
        compares = 0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 7; i++) begin
            rdReg(rstAddr[i], v);
            check(v, rstVal[i]);
        end
        $display("test reset values done");
        wrReg(8'h92, 8'h5a);
        rdReg(8'h92, v);
        check(v, 8'h5a);
        wrReg(8'h11, 8'h33);
        wrReg(8'h12, 8'hfb);
        rdReg(8'h12, v);
        check(v, 8'h7b);
        repeat (100) @(posedge clk);
        rdReg(8'h11, v);
        check(v, 8'h33);
        $display("test access and off done");
        wrReg(8'h92, 8'hff);
        for (int p = 0; p < 4; p++) begin
            int r;
            r = (p == 0) ? 1 : (p == 1) ? 4 : 16;
            wrReg(8'h11, 8'h00);
            wrReg(8'h12, {6'h00, p[1:0]} | 8'h04);
            // On for exactly 32 * r edges: eight increments whatever the divider phase
            repeat (32 * r - 2) @(posedge clk);
            wrReg(8'h12, 8'h00);
            rdReg(8'h11, v);
            check(v, 8'h08);
        end
        $display("test prescaler done");
        wrReg(8'h0b, 8'hc0);
        wrReg(8'h8c, 8'h02);
        wrReg(8'h92, 8'h02);
        for (int j = 0; j < 3; j++) begin
            wrReg(8'h11, 8'h00);
            wrReg(8'h0c, 8'h00);
            wrReg(8'h12, {1'b0, postSel[j], 3'b100});
            // Flag due 12 * (select + 1) clocks on, give or take the divider phase
            repeat (12 * postSel[j] + 3) @(posedge clk);
            rdReg(8'h0c, v);
            check(v, 8'h00);
            check({7'h00, irqReq}, 8'h00);
            repeat (14) @(posedge clk);
            rdReg(8'h0c, v);
            check(v, 8'h02);
            check({7'h00, irqReq}, 8'h01);
            wrReg(8'h12, 8'h00);
        end
        repeat (50) @(posedge clk);
        rdReg(8'h0c, v);
        check(v, 8'h02);
        wrReg(8'h0b, 8'h80);
        rdReg(8'h0b, v);
        check(v, 8'h80);
        check({7'h00, irqReq}, 8'h00);
        wrReg(8'h0b, 8'hc0);
        rdReg(8'h0c, v);
        check({7'h00, irqReq}, 8'h01);
        wrReg(8'h0c, 8'h00);
        rdReg(8'h0c, v);
        check(v, 8'h00);
        check({7'h00, irqReq}, 8'h00);
        $display("test postscaler and flag done");
        wrReg(8'h92, 8'hff);
        wrReg(8'h12, 8'h06);
        // Writes every 42 clocks starve a 1:16 prescaler if they clear it
        for (int k = 0; k < 6; k++) begin
            repeat (40) @(posedge clk);
            if (k[0])
                wrReg(8'h12, 8'h06);
            else
                wrReg(8'h11, 8'h10);
        end
        rdReg(8'h11, v);
        check(v, 8'h10);
        check(pwmBase.count, 8'h10);
        $display("test scaler clearing done");
        conclude();
    end
endmodule : pts_timer_bench
